// ==== hw/tpw_cfg.svh ====
/*
 * register offsets, field positions, reset values and timing counts
 * for the dual-slope pwm timer block.
 * assumes: included by its bare name from the design, monitor and bench.
 */
`ifndef TPW_CFG_SVH
`define TPW_CFG_SVH

// register indices on the plain register port
`define TPW_ADDR_OMC        6'h30
`define TPW_ADDR_CMC        6'h33
`define TPW_ADDR_CNT        6'h32
`define TPW_ADDR_CMPA       6'h36
`define TPW_ADDR_CMPB       6'h3c
`define TPW_ADDR_FLAGS      6'h38

// output mode control fields
`define TPW_OMC_A_HI        7
`define TPW_OMC_A_LO        6
`define TPW_OMC_B_HI        5
`define TPW_OMC_B_LO        4
`define TPW_OMC_WMASK       8'hf3
`define TPW_OMC_RESET       8'h00

// clock mode control fields
`define TPW_CMC_UPPER       3
`define TPW_CMC_CS_HI       2
`define TPW_CMC_WMASK       8'h0f
`define TPW_CMC_RESET       8'h00

// flag register bits
`define TPW_FLAG_WRAP       0
`define TPW_FLAG_MATCH_A    1
`define TPW_FLAG_MATCH_B    2

// counter limits
`define TPW_BOTTOM          8'h00
`define TPW_MAX             8'hff

// prescale terminal counts (factor minus one)
`define TPW_DIV8_LAST       10'h007
`define TPW_DIV64_LAST      10'h03f
`define TPW_DIV256_LAST     10'h0ff
`define TPW_DIV1024_LAST    10'h3ff

`endif

// ==== hw/tpw_pkg.sv ====
/*
 * types for the dual-slope pwm timer block.
 * assumes: tpw_cfg.svh on the include path.
 */
package tpw_pkg;

    typedef enum logic [2:0] {
        TPW_SHAPE_NORMAL,
        TPW_SHAPE_PC_FF,
        TPW_SHAPE_CTC,
        TPW_SHAPE_FAST_FF,
        TPW_SHAPE_RSV4,
        TPW_SHAPE_PC_CMP,
        TPW_SHAPE_RSV6,
        TPW_SHAPE_FAST_CMP
    } tpw_shape_e;

    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tpw_bus_req_s;

    typedef struct packed {
        logic wave_a;
        logic wave_b;
        logic override_a;
        logic override_b;
    } tpw_pins_s;

endpackage : tpw_pkg

// ==== hw/tpw_timer.sv ====
/*
 * dual-slope pwm timer with output a/b compare actions and register port.
 * assumes: one clock core_clk, synchronous active-high reset, a register
 * master that holds strobes for one cycle and takes read data next cycle.
 */
// Behaviour
// - shape select 1 or 5 is dual-slope; top 0xff or compare a.
// - dual-slope counts up to top then down to bottom, repeating.
// - counter holds top for exactly one tick before decrementing.
// - wrap flag sets each time counter reaches bottom in dual-slope.
// - action 10 dual-slope clears on up match, sets on down match.
// - action 11 dual-slope sets on up match, clears on down match.
// - action 01 in pwm toggles a when upper bit set, else disconnected.
// - action 00 disconnects output, pin stays under port control.
// - nonzero action overrides pin, except 01 in pwm (b always, a without upper bit); software must also set pin direction.
// - non-pwm modes: 01 toggles, 10 clears, 11 sets on match.
// - fast pwm: 10 clears on match sets at bottom; 11 opposite.
// - fast pwm, compare equals top, upper bit: match ignored, bottom acts.
// - dual-slope, compare equals top, upper bit: match ignored, top acts.
// - dual-slope, action 10: compare at bottom gives constant low, at max constant high; 11 the opposite.
// - output while compare is max equals down-match result.
// - start above compare still gives symmetric transition at bottom.
// - with top 0xff the period is 510 ticks; prescale 1..1024.
// - fully synchronous; prescaled tick only enables counting, output updates, compare load and flags.
// - control a: a action 7:6, b action 5:4, mode 1:0, 3:2 zero.
// - new action value takes effect at first compare match after write.
// - upper mode bit in control b, forms three-bit shape select.
`timescale 1ns/1ps
`include "tpw_cfg.svh"

module tpw_timer (
    input  wire logic              core_clk,
    input  wire logic              reset,
    input  wire tpw_pkg::tpw_bus_req_s bus_req,
    output logic [7:0]             bus_rdata,
    output logic                   wave_out_a,
    output logic                   wave_out_b,
    output logic                   wave_a_override,
    output logic                   wave_b_override,
    output logic                   wrap_flag,
    output logic                   match_a_flag,
    output logic                   match_b_flag
);
    import tpw_pkg::*;

    // registers
    logic [7:0] omc_q;
    logic [7:0] cmc_q;
    logic [7:0] count_q;
    logic [7:0] cmpa_buf_q;
    logic [7:0] cmpb_buf_q;
    logic [7:0] cmpa_q;
    logic [7:0] cmpb_q;
    logic       down_q;
    logic [9:0] pre_q;
    logic       wave_a_q;
    logic       wave_b_q;
    logic [2:0] flags_q;
    logic [7:0] rdata_q;
    logic       ovr_a_q;
    logic       ovr_b_q;

    // decoded configuration
    wire logic [1:0] out_a_action = omc_q[`TPW_OMC_A_HI:`TPW_OMC_A_LO];
    wire logic [1:0] out_b_action = omc_q[`TPW_OMC_B_HI:`TPW_OMC_B_LO];
    wire logic       wave_shape_upper_bit = cmc_q[`TPW_CMC_UPPER];
    wire tpw_shape_e wave_shape_select =
        tpw_shape_e'({wave_shape_upper_bit, omc_q[1:0]});
    wire logic [2:0] clk_sel = cmc_q[`TPW_CMC_CS_HI:0];

    function automatic logic is_dual(input tpw_shape_e s);
        is_dual = (s == TPW_SHAPE_PC_FF) || (s == TPW_SHAPE_PC_CMP);
    endfunction : is_dual

    function automatic logic is_fast(input tpw_shape_e s);
        is_fast = (s == TPW_SHAPE_FAST_FF) || (s == TPW_SHAPE_FAST_CMP);
    endfunction : is_fast

    wire logic dual = is_dual(wave_shape_select);
    wire logic fast = is_fast(wave_shape_select);
    wire logic top_from_cmp = wave_shape_select == TPW_SHAPE_PC_CMP ||
                              wave_shape_select == TPW_SHAPE_FAST_CMP ||
                              wave_shape_select == TPW_SHAPE_CTC;
    // compare registers in use: buffered in pwm modes, direct otherwise
    wire logic [7:0] cmpa_use = (dual || fast) ? cmpa_q : cmpa_buf_q;
    wire logic [7:0] cmpb_use = (dual || fast) ? cmpb_q : cmpb_buf_q;
    wire logic [7:0] top_val = top_from_cmp ? cmpa_use : `TPW_MAX;

    // prescaled tick, an enable only
    wire logic pre_hit =
        (clk_sel == 3'h2 && {7'h00, pre_q[2:0]} == `TPW_DIV8_LAST) ||
        (clk_sel == 3'h3 && {4'h0, pre_q[5:0]} == `TPW_DIV64_LAST) ||
        (clk_sel == 3'h4 && {2'h0, pre_q[7:0]} == `TPW_DIV256_LAST) ||
        (clk_sel == 3'h5 && pre_q == `TPW_DIV1024_LAST);
    wire logic timer_tick_enable = (clk_sel == 3'h1) || pre_hit;

    // counter stepping
    wire logic at_top    = count_q == top_val;
    wire logic at_bottom = count_q == `TPW_BOTTOM;
    // direction for this tick: turn at top after showing it once
    wire logic going_down = dual && (down_q || at_top) && !at_bottom;
    logic [7:0] count_d;
    always_comb begin
        if (dual) begin
            if (at_top && !down_q)
                count_d = count_q - 8'h01;
            else if (down_q && !at_bottom)
                count_d = count_q - 8'h01;
            else
                count_d = count_q + 8'h01;
        end else if (at_top && wave_shape_select != TPW_SHAPE_NORMAL) begin
            count_d = `TPW_BOTTOM;
        end else begin
            count_d = count_q + 8'h01;
        end
    end
    wire logic down_d = dual ? ((down_q && !at_bottom) ||
                                (!down_q && at_top)) : 1'b0;
    // reaching bottom on the next count; top: at top now, before turning
    wire logic next_bottom = count_d == `TPW_BOTTOM;
    wire logic next_top    = dual && at_top && !down_q;

    // compare match on the value present during this tick
    wire logic match_a = count_q == cmpa_use;
    wire logic match_b = count_q == cmpb_use;

    // wave a/b action; returns {act, level_or_toggle, is_toggle}
    function automatic logic [2:0] act_of(
        input logic [1:0] act,
        input logic       mtch,
        input logic       down,
        input logic       bottom,
        input logic       topped,
        input logic       cmp_is_top,
        input logic       allow_tog,
        input logic       d_mode,
        input logic       f_mode,
        input logic       up_bit
    );
        act_of = 3'b000;
        if (act == 2'b00) begin
            act_of = 3'b000;
        end else if (!d_mode && !f_mode) begin
            if (mtch) begin
                if (act == 2'b01)
                    act_of = 3'b101;
                else
                    act_of = {1'b1, act[0], 1'b0};
            end
        end else if (act == 2'b01) begin
            if (allow_tog && up_bit && mtch)
                act_of = 3'b101;
        end else if (f_mode) begin
            if (bottom)
                act_of = {1'b1, ~act[0], 1'b0};
            else if (mtch && !cmp_is_top)
                act_of = {1'b1, act[0], 1'b0};
        end else begin
            // compare at top: level as after a down match, so it stays steady
            if (topped && cmp_is_top)
                act_of = {1'b1, ~act[0], 1'b0};
            else if (bottom)
                act_of = {1'b1, ~act[0], 1'b0};
            else if (mtch && !cmp_is_top)
                act_of = {1'b1, act[0] ^ down, 1'b0};
        end
    endfunction : act_of

    // at bottom, unless compare is also bottom, the level is forced to the down-match result, which keeps
    // the waveform symmetric even if the up match was missed
    wire logic [2:0] act_a = act_of(out_a_action, match_a, going_down,
        at_bottom && (fast ? count_q != cmpa_use : 1'b1) ?
            (fast ? 1'b0 : (count_q != cmpa_use)) : 1'b0,
        at_top && !down_q, cmpa_use == top_val, 1'b1, dual, fast,
        wave_shape_upper_bit);
    wire logic [2:0] act_b = act_of(out_b_action, match_b, going_down,
        dual && at_bottom && count_q != cmpb_use,
        at_top && !down_q, cmpb_use == top_val, 1'b0, dual, fast,
        wave_shape_upper_bit);
    // fast pwm bottom action happens as the counter wraps to bottom
    wire logic fa_bot = fast && at_top;
    wire logic [2:0] act_a_f = act_of(out_a_action, match_a, 1'b0, fa_bot,
        1'b0, cmpa_use == top_val, 1'b1, 1'b0, 1'b1, wave_shape_upper_bit);
    wire logic [2:0] act_b_f = act_of(out_b_action, match_b, 1'b0, fa_bot,
        1'b0, cmpb_use == top_val, 1'b0, 1'b0, 1'b1, wave_shape_upper_bit);
    wire logic [2:0] sel_a = fast ? act_a_f : act_a;
    wire logic [2:0] sel_b = fast ? act_b_f : act_b;

    // actions read live bits, so a new value acts at the next match
    wire logic wave_a_d = !sel_a[2] ? wave_a_q :
                          (sel_a[0] ? ~wave_a_q : sel_a[1]);
    wire logic wave_b_d = !sel_b[2] ? wave_b_q :
                          (sel_b[0] ? ~wave_b_q : sel_b[1]);

    // register port decode
    wire logic wr_omc  = bus_req.wr && bus_req.addr == `TPW_ADDR_OMC;
    wire logic wr_cmc  = bus_req.wr && bus_req.addr == `TPW_ADDR_CMC;
    wire logic wr_cnt  = bus_req.wr && bus_req.addr == `TPW_ADDR_CNT;
    wire logic wr_cmpa = bus_req.wr && bus_req.addr == `TPW_ADDR_CMPA;
    wire logic wr_cmpb = bus_req.wr && bus_req.addr == `TPW_ADDR_CMPB;
    wire logic wr_flg  = bus_req.wr && bus_req.addr == `TPW_ADDR_FLAGS;
    logic [7:0] rd_mux;
    always_comb begin
        unique case (bus_req.addr)
            `TPW_ADDR_OMC:   rd_mux = omc_q;
            `TPW_ADDR_CMC:   rd_mux = cmc_q;
            `TPW_ADDR_CNT:   rd_mux = count_q;
            `TPW_ADDR_CMPA:  rd_mux = cmpa_buf_q;
            `TPW_ADDR_CMPB:  rd_mux = cmpb_buf_q;
            `TPW_ADDR_FLAGS: rd_mux = {5'h00, flags_q};
            default:         rd_mux = 8'h00;
        endcase
    end

    // flag events, set wins over a write-one clear
    wire logic wrap_ev = timer_tick_enable &&
        (dual ? next_bottom && down_q : at_top && !top_from_cmp);
    wire logic [2:0] flag_set = {timer_tick_enable && match_b,
                                 timer_tick_enable && match_a, wrap_ev};
    wire logic [2:0] flag_clr = wr_flg ? bus_req.wdata[2:0] : 3'h0;
    wire logic [2:0] flags_d = flag_set | (flags_q & ~flag_clr);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            omc_q <= `TPW_OMC_RESET;
            cmc_q <= `TPW_CMC_RESET;
        end else begin
            if (wr_omc)
                omc_q <= bus_req.wdata & `TPW_OMC_WMASK;
            if (wr_cmc)
                cmc_q <= bus_req.wdata & `TPW_CMC_WMASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset)
            pre_q <= 10'h000;
        else
            pre_q <= pre_q + 10'h001;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            count_q <= `TPW_BOTTOM;
            down_q  <= 1'b0;
        end else if (wr_cnt) begin
            count_q <= bus_req.wdata;
            down_q  <= 1'b0;
        end else if (timer_tick_enable) begin
            count_q <= count_d;
            down_q  <= down_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            cmpa_buf_q <= 8'h00;
            cmpb_buf_q <= 8'h00;
        end else begin
            if (wr_cmpa)
                cmpa_buf_q <= bus_req.wdata;
            if (wr_cmpb)
                cmpb_buf_q <= bus_req.wdata;
        end
    end

    // active compare load: at top in dual-slope, at bottom in fast pwm
    wire logic load_cmp = !(dual || fast) ||
        (timer_tick_enable && (dual ? next_top : at_top));
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cmpa_q <= 8'h00;
            cmpb_q <= 8'h00;
        end else if (load_cmp) begin
            cmpa_q <= cmpa_buf_q;
            cmpb_q <= cmpb_buf_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            wave_a_q <= 1'b0;
            wave_b_q <= 1'b0;
            flags_q  <= 3'h0;
        end else begin
            if (timer_tick_enable) begin
                wave_a_q <= wave_a_d;
                wave_b_q <= wave_b_d;
            end
            flags_q <= flags_d;
        end
    end

    // pin override when action nonzero, but 01 in pwm: b never, a only with upper bit
    wire logic ovr_a_d = out_a_action != 2'b00 &&
        !((dual || fast) && out_a_action == 2'b01 &&
          !wave_shape_upper_bit);
    wire logic ovr_b_d = out_b_action != 2'b00 &&
        !((dual || fast) && out_b_action == 2'b01);
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdata_q <= 8'h00;
            ovr_a_q <= 1'b0;
            ovr_b_q <= 1'b0;
        end else begin
            rdata_q <= bus_req.rd ? rd_mux : 8'h00;
            ovr_a_q <= ovr_a_d;
            ovr_b_q <= ovr_b_d;
        end
    end

    assign bus_rdata       = rdata_q;
    assign wave_out_a      = wave_a_q;
    assign wave_out_b      = wave_b_q;
    assign wave_a_override = ovr_a_q;
    assign wave_b_override = ovr_b_q;
    assign wrap_flag       = flags_q[`TPW_FLAG_WRAP];
    assign match_a_flag    = flags_q[`TPW_FLAG_MATCH_A];
    assign match_b_flag    = flags_q[`TPW_FLAG_MATCH_B];

endmodule : tpw_timer

// ==== testbench/tpw_timer_monitor.sv ====
/*
 * port checker for the dual-slope pwm timer.
 * assumes: bound to tpw_timer, tpw_cfg.svh on the include path.
 */
`timescale 1ns/1ps
`include "tpw_cfg.svh"

module tpw_timer_monitor (
    input wire logic                  core_clk,
    input wire logic                  reset,
    input wire tpw_pkg::tpw_bus_req_s bus_req,
    input wire logic [7:0]            bus_rdata,
    input wire logic                  wave_out_a,
    input wire logic                  wave_out_b,
    input wire logic                  wave_a_override,
    input wire logic                  wave_b_override,
    input wire logic                  wrap_flag,
    input wire logic                  match_a_flag,
    input wire logic                  match_b_flag
);
    import tpw_pkg::*;

    logic stop_q, stop1_q, stop2_q, armed_q;
    wire  w_omc  = bus_req.wr && bus_req.addr == `TPW_ADDR_OMC;
    wire  w_cmc  = bus_req.wr && bus_req.addr == `TPW_ADDR_CMC;
    wire  w_flg  = bus_req.wr && bus_req.addr == `TPW_ADDR_FLAGS;
    wire  r_omc  = bus_req.rd && bus_req.addr == `TPW_ADDR_OMC;
    wire  r_cmc  = bus_req.rd && bus_req.addr == `TPW_ADDR_CMC;
    wire  cs_off = bus_req.wdata[2:0] == 3'h0 || bus_req.wdata[2:0] > 3'h5;
    wire  mapped = bus_req.addr inside {`TPW_ADDR_OMC, `TPW_ADDR_CMC,
        `TPW_ADDR_CNT, `TPW_ADDR_CMPA, `TPW_ADDR_CMPB, `TPW_ADDR_FLAGS};

    // shadow of clock select and of any output a action ever armed
    always_ff @(posedge core_clk) begin
        if (reset) begin
            stop_q  <= 1'b1;
            stop1_q <= 1'b1;
            stop2_q <= 1'b1;
            armed_q <= 1'b0;
        end else begin
            if (w_cmc) stop_q <= cs_off;
            stop1_q <= stop_q;
            stop2_q <= stop1_q;
            if (w_omc && |bus_req.wdata[7:6]) armed_q <= 1'b1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    AST_RDATA_IDLE: assert property (
        !$past(bus_req.rd) |-> bus_rdata == 8'h00)
        else $error("read data not zero outside read slot");
    AST_UNMAPPED: assert property (
        $past(bus_req.rd) && !$past(mapped) |-> bus_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_OMC_RSV: assert property (
        $past(r_omc) |-> bus_rdata[3:2] == 2'b00)
        else $error("reserved control bits not zero");
    AST_OMC_RW: assert property (
        $past(w_omc, 2) && $past(r_omc) |->
        bus_rdata == ($past(bus_req.wdata, 2) & `TPW_OMC_WMASK))
        else $error("output mode control readback wrong");
    AST_CMC_RW: assert property (
        $past(w_cmc, 2) && $past(r_cmc) |->
        bus_rdata == ($past(bus_req.wdata, 2) & `TPW_CMC_WMASK))
        else $error("clock mode control readback wrong");
    AST_WRAP_HOLD: assert property (
        $fell(wrap_flag) |-> $past(w_flg && bus_req.wdata[0]))
        else $error("wrap flag dropped without clear");
    AST_MATCHA_HOLD: assert property (
        $fell(match_a_flag) |-> $past(w_flg && bus_req.wdata[1]))
        else $error("match a flag dropped without clear");
    AST_STOP_STABLE: assert property (
        stop_q && stop1_q && stop2_q |->
        $stable(wave_out_a) && $stable(wave_out_b))
        else $error("waveform moved while timer stopped");
    AST_A_DISCONNECT: assert property (
        !armed_q |-> !wave_a_override)
        else $error("output a took pin with action zero");
endmodule : tpw_timer_monitor

bind tpw_timer tpw_timer_monitor i_mon (.core_clk(core_clk),
    .reset(reset), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
    .wave_a_override(wave_a_override), .wave_b_override(wave_b_override),
    .wrap_flag(wrap_flag), .match_a_flag(match_a_flag),
    .match_b_flag(match_b_flag));

// ==== testbench/tpw_timer_bench.sv ====
/*
 * self-checking bench for the dual-slope pwm timer.
 * assumes: tpw_pkg compiled first, tpw_cfg.svh on the include path.
 */
`timescale 1ns/1ps
`include "tpw_cfg.svh"

module tpw_timer_bench;
    import tpw_pkg::*;

    logic         core_clk, reset, rd_seen;
    tpw_bus_req_s bus_req;
    logic [7:0]   bus_rdata;
    logic         wave_out_a, wave_out_b, wave_a_override, wave_b_override;
    logic         wrap_flag, match_a_flag, match_b_flag;
    logic [7:0]   exp_q[$];
    logic [31:0]  rng;
    int           fails, n_compared, hi, per, chg;
    logic         lvl;
    logic [7:0]   t_omc[6] = '{8'h81, 8'hc1, 8'h81, 8'h41, 8'h83, 8'h42};
    logic [7:0]   t_cmp[6] = '{8'h40, 8'h40, 8'h40, 8'h20, 8'h40, 8'h20};
    logic [7:0]   t_cmc[6] = '{8'h01, 8'h01, 8'h02, 8'h09, 8'h01, 8'h01};
    int           t_hi[6]  = '{128, 382, 1024, 64, 65, 33};
    int           t_per[6] = '{510, 510, 4080, 128, 256, 66};
    logic [7:0]   c_omc[3] = '{8'h81, 8'h81, 8'hc1};
    logic [7:0]   c_cmp[3] = '{8'h00, 8'hff, 8'h00};
    logic [7:0]   c_lvl[3] = '{8'h00, 8'h01, 8'h01};

    tpw_timer i_tpw_timer (.core_clk(core_clk), .reset(reset),
        .bus_req(bus_req), .bus_rdata(bus_rdata), .wave_out_a(wave_out_a),
        .wave_out_b(wave_out_b), .wave_a_override(wave_a_override),
        .wave_b_override(wave_b_override), .wrap_flag(wrap_flag),
        .match_a_flag(match_a_flag), .match_b_flag(match_b_flag));

    function automatic logic [31:0] xorshift(logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xorshift

    task automatic check(string what, logic [7:0] exp, logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic check_n(string what, int exp, int got);
        n_compared++;
        if (got != exp) begin
            fails++;
            $display("[ERR] %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_n

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic wr(logic [5:0] a, logic [7:0] d);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge core_clk);
    endtask : wr

    task automatic rd(logic [5:0] a, logic [7:0] e);
        bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        exp_q.push_back(e);
        @(posedge core_clk);
    endtask : rd

    task automatic idle;
        bus_req <= '0;
        @(posedge core_clk);
    endtask : idle

    task automatic setup(logic [7:0] omc, logic [7:0] cmp, logic [7:0] cmc);
        @(posedge core_clk);
        wr(`TPW_ADDR_CMC, 8'h00);
        wr(`TPW_ADDR_OMC, 8'h00);
        wr(`TPW_ADDR_CNT, 8'h00);
        wr(`TPW_ADDR_CMPA, cmp);
        wr(`TPW_ADDR_OMC, omc);
        wr(`TPW_ADDR_CMC, cmc);
        idle();
    endtask : setup

    task automatic step_until(logic v, output int n);
        n = 0;
        #1;
        while (wave_out_a !== v && n < 5000) begin
            @(posedge core_clk);
            #1;
            n++;
        end
    endtask : step_until

    task automatic measure(output int h, output int p);
        int n, lo;
        step_until(1'b0, n);
        step_until(1'b1, n);
        step_until(1'b0, h);
        step_until(1'b1, lo);
        p = h + lo;
    endtask : measure

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // read results land one cycle after the strobe
    always @(posedge core_clk) rd_seen <= bus_req.rd;
    always @(negedge core_clk) begin
        if (rd_seen === 1'b1) check("rdata", exp_q.pop_front(), bus_rdata);
    end

    initial begin
        #(40 * 40000);
        fails++;
        tally_and_finish();
    end

    initial begin
        bus_req = '0;
        reset = 1'b1;
        rng = 32'd80;
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        rd(`TPW_ADDR_OMC, `TPW_OMC_RESET);
        rd(`TPW_ADDR_CMC, `TPW_CMC_RESET);
        rd(6'h01, 8'h00);
        check("override_a", 8'h00, {7'h0, wave_a_override});
        repeat (6) begin
            rng = xorshift(rng);
            wr(`TPW_ADDR_OMC, rng[7:0]);
            rd(`TPW_ADDR_OMC, rng[7:0] & `TPW_OMC_WMASK);
            wr(`TPW_ADDR_CMC, rng[15:8]);
            rd(`TPW_ADDR_CMC, rng[15:8] & `TPW_CMC_WMASK);
        end
        for (int i = 0; i < 6; i++) begin
            setup(t_omc[i], t_cmp[i], t_cmc[i]);
            measure(hi, per);
            check_n("high", t_hi[i], hi);
            check_n("period", t_per[i], per);
            check("override_a", 8'h01, {7'h0, wave_a_override});
            check("override_b", 8'h00, {7'h0, wave_b_override});
        end
        check("wrap", 8'h01, {7'h0, wrap_flag});
        check("match_a", 8'h01, {7'h0, match_a_flag});
        @(posedge core_clk);
        wr(`TPW_ADDR_CMC, 8'h00);
        wr(`TPW_ADDR_FLAGS, 8'h07);
        idle();
        check("wrap", 8'h00, {7'h0, wrap_flag});
        check("match_a", 8'h00, {7'h0, match_a_flag});
        setup(8'h41, 8'h20, 8'h01);
        repeat (600) @(posedge core_clk);
        check("override_a", 8'h00, {7'h0, wave_a_override});
        for (int j = 0; j < 3; j++) begin
            setup(c_omc[j], c_cmp[j], 8'h01);
            repeat (520) @(posedge core_clk);
            #1;
            lvl = wave_out_a;
            chg = 0;
            repeat (520) begin
                @(posedge core_clk);
                #1;
                if (wave_out_a !== lvl) chg++;
            end
            check("level", c_lvl[j], {7'h0, lvl});
            check_n("changes", 0, chg);
        end
        tally_and_finish();
    end
endmodule : tpw_timer_bench
